// ### port6_io.sv
// Port 6 general I/O and bus control pins with port 5 pull-up control.
module port6_io (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  hw_standby,
   input  wire logic                  sw_standby,
   input  wire logic [2:0]            op_mode,
   input  wire logic [15:0]           avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [7:0]            avs_writedata,
   output logic      [7:0]            avs_readdata,
   output logic                       avs_waitrequest,
   input  wire port6_pkg::bus_ctrl_t  bus_ctrl,
   output logic                       wait_n,
   input  wire logic [7:0]            p6_pin_in,
   output logic      [7:0]            p6_pin_out,
   output logic      [7:0]            p6_pin_oe,
   output logic      [3:0]            p5_pullup_on
);

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   // Modes 1, 3 and 5 hand pins 5 to 3 to the bus controller, and modes 5
   // to 7 allow the port 5 pull-ups; other codes count as neither.
   function automatic logic is_expanded(input logic [2:0] m);
      return (m == port6_pkg::MODE_1) || (m == port6_pkg::MODE_3) ||
             (m == port6_pkg::MODE_5);
   endfunction

   function automatic logic pullup_allowed(input logic [2:0] m);
      return (m == port6_pkg::MODE_5) || (m == port6_pkg::MODE_6) ||
             (m == port6_pkg::MODE_7);
   endfunction

   // The mode pins are static; reset values that depend on them are only
   // reloaded through reset or hardware standby.
   logic expanded;
   logic init;
   assign expanded = is_expanded(op_mode);
   assign init     = hw_standby;

   // ****************************************************************
   // Bus front end and pin input synchroniser
   // ****************************************************************
   logic                 req_valid;
   port6_pkg::bus_req_t  req;
   logic [7:0]           pin_level;

   // A fixed wait state lets read data come from a register, at the cost
   // of three cycles for every access.
   avalon_slave u_slave (
      .core_clk        (core_clk),
      .rst             (rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_waitrequest (avs_waitrequest),
      .req_valid       (req_valid),
      .req             (req)
   );

   // Pin levels pass three synchroniser stages and a filter flop, so a read of an input pin lags the board
   // by three to four cycles.
   pin_sync u_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_in    (p6_pin_in),
      .pin_level (pin_level)
   );

   logic wr_hit;
   assign wr_hit = req_valid && req.write;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] p6_dir_r;
   logic [7:0] p6_data_r;
   logic [7:0] p5_pullup_r;
   logic [7:0] p5_dir_r;
   logic [7:0] wait_enable_r;
   logic [7:0] wait_ctrl_r;
   logic       init_d_r;

   // Hardware standby acts like reset on all port state; software standby
   // needs nothing here because registers simply keep their values.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         init_d_r <= 1'b1;
      end else begin
         init_d_r <= init;
      end
   end

   // The expanded-mode reset value needs the mode pins, so it is loaded on
   // the first clock after reset or hardware standby rather than inside the reset.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p6_dir_r <= port6_pkg::P6_DIR_RESET;
      end else if (init || init_d_r) begin
         p6_dir_r <= expanded ? port6_pkg::P6_DIR_RESET_EXP
                              : port6_pkg::P6_DIR_RESET;
      end else if (wr_hit && req.address == port6_pkg::ADDR_P6_DIRECTION) begin
         p6_dir_r <= req.writedata;
      end
   end

   // Bit 7 is forced high on every write, so it can never read back as 0.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p6_data_r <= port6_pkg::P6_DATA_RESET;
      end else if (init) begin
         p6_data_r <= port6_pkg::P6_DATA_RESET;
      end else if (wr_hit && req.address == port6_pkg::ADDR_P6_DATA) begin
         p6_data_r <= req.writedata | port6_pkg::P6_FIXED_ONE;
      end
   end

   // ****************************************************************
   // Port 5 registers
   // ****************************************************************

   // The upper pull-up bits have no pin; every write forces them back to 1.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p5_pullup_r <= port6_pkg::P5_PULLUP_RESET;
      end else if (init) begin
         p5_pullup_r <= port6_pkg::P5_PULLUP_RESET;
      end else if (wr_hit && req.address == port6_pkg::ADDR_P5_PULLUP) begin
         p5_pullup_r <= req.writedata | port6_pkg::P5_PULLUP_RESET;
      end
   end

   // Port 5 direction is kept only to gate the pull-ups; like the port 6
   // direction register it reads as all ones.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p5_dir_r <= port6_pkg::P5_DIR_RESET_57;
      end else if (init || init_d_r) begin
         p5_dir_r <= pullup_allowed(op_mode) ? port6_pkg::P5_DIR_RESET_57
                                             : port6_pkg::P5_DIR_RESET_13;
      end else if (wr_hit && req.address == port6_pkg::ADDR_P5_DIRECTION) begin
         p5_dir_r <= req.writedata | port6_pkg::P5_DIR_RESET_57;
      end
   end

   // ****************************************************************
   // Wait control registers
   // ****************************************************************

   // These copy the bus controller's wait settings that decide the role
   // of pin 0; no other field of them has any effect here.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_enable_r <= port6_pkg::WAIT_ENABLE_RESET;
         wait_ctrl_r   <= port6_pkg::WAIT_CONTROL_RESET;
      end else if (init) begin
         wait_enable_r <= port6_pkg::WAIT_ENABLE_RESET;
         wait_ctrl_r   <= port6_pkg::WAIT_CONTROL_RESET;
      end else if (wr_hit) begin
         if (req.address == port6_pkg::ADDR_WAIT_ENABLE) begin
            wait_enable_r <= req.writedata;
         end else if (req.address == port6_pkg::ADDR_WAIT_CONTROL) begin
            wait_ctrl_r <= req.writedata;
         end
      end
   end

   // ****************************************************************
   // Pin function selection
   // ****************************************************************
   logic       pin0_general;
   logic [7:0] pin_mask;
   logic [7:0] out_nxt;
   logic [7:0] oe_nxt;

   assign pin0_general = (&wait_enable_r) &&
                         !wait_ctrl_r[port6_pkg::WAIT_MODE_HI_BIT];
   assign pin_mask = port6_pkg::P6_PIN_MASK;

   // Only pins 5, 4, 3 and 0 exist; the mask keeps reserved direction
   // bits from ever reaching an output enable.
   always_comb begin
      out_nxt = p6_data_r & pin_mask;
      oe_nxt  = p6_dir_r & pin_mask;
      if (expanded) begin
         out_nxt[port6_pkg::P6_WR_BIT] = bus_ctrl.write_strobe_n;
         out_nxt[port6_pkg::P6_RD_BIT] = bus_ctrl.read_strobe_n;
         out_nxt[port6_pkg::P6_AS_BIT] = bus_ctrl.address_strobe_n;
         oe_nxt[port6_pkg::P6_WR_BIT]  = 1'b1;
         oe_nxt[port6_pkg::P6_RD_BIT]  = 1'b1;
         oe_nxt[port6_pkg::P6_AS_BIT]  = 1'b1;
         if (!pin0_general) begin
            oe_nxt[port6_pkg::P6_WAIT_BIT] = 1'b0;
         end
      end
      if (init) begin
         oe_nxt = 8'h00;
      end
   end

   // Pin drive is registered; with software standby nothing changes, so
   // every enabled output keeps its last level except bus strobe pins 5 to 3 in modes 1, 3 and 5.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p6_pin_out <= 8'h00;
         p6_pin_oe  <= 8'h00;
      end else begin
         p6_pin_out <= out_nxt;
         p6_pin_oe  <= oe_nxt;
      end
   end

   // Outside the wait role the bus controller sees a released wait, so a
   // floating pin 0 cannot stall it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_n <= 1'b1;
      end else begin
         wait_n <= (expanded && !pin0_general) ?
                   pin_level[port6_pkg::P6_WAIT_BIT] : 1'b1;
      end
   end

   // ****************************************************************
   // Port 5 pull-ups
   // ****************************************************************
   logic [3:0] pullup_nxt;

   // The pull-ups also stay off in the cycle after reset, while the port 5
   // direction register takes its mode-dependent value.
   always_comb begin
      pullup_nxt = p5_pullup_r[3:0] & ~p5_dir_r[3:0];
      if (!pullup_allowed(op_mode)) begin
         pullup_nxt = 4'h0;
      end
      if (init || init_d_r) begin
         pullup_nxt = 4'h0;
      end
   end

   // Software standby is not gated: held registers give the held state.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p5_pullup_on <= 4'h0;
      end else begin
         p5_pullup_on <= pullup_nxt;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] data_view;

   // Store bits 6, 2 and 1 read as ones while their direction bit is clear,
   // so software cannot tell them from bits with no storage.
   assign data_view = port6_pkg::P6_FIXED_ONE |
      (p6_dir_r & p6_data_r) |
      (~p6_dir_r & pin_mask & pin_level) |
      (~p6_dir_r & port6_pkg::P6_STORE_MASK);

   // Unmapped addresses read as zero; writes to them are dropped.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 8'h00;
      end else if (req_valid && req.read) begin
         if (req.address == port6_pkg::ADDR_P6_DIRECTION) begin
            avs_readdata <= port6_pkg::READ_ONES;
         end else if (req.address == port6_pkg::ADDR_P5_DIRECTION) begin
            avs_readdata <= port6_pkg::READ_ONES;
         end else if (req.address == port6_pkg::ADDR_P6_DATA) begin
            avs_readdata <= data_view;
         end else if (req.address == port6_pkg::ADDR_P5_PULLUP) begin
            avs_readdata <= p5_pullup_r;
         end else if (req.address == port6_pkg::ADDR_WAIT_ENABLE) begin
            avs_readdata <= wait_enable_r;
         end else if (req.address == port6_pkg::ADDR_WAIT_CONTROL) begin
            avs_readdata <= wait_ctrl_r;
         end else begin
            avs_readdata <= 8'h00;
         end
      end
   end

endmodule

// ### port6_pkg.sv
// Shared constants and carrier types for the port 6 / port 5 pull-up block.
package port6_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [15:0] ADDR_P5_DIRECTION = 16'hffc8;
   localparam logic [15:0] ADDR_P6_DIRECTION = 16'hffc9;
   localparam logic [15:0] ADDR_P6_DATA      = 16'hffcb;
   localparam logic [15:0] ADDR_P5_PULLUP    = 16'hffdb;
   localparam logic [15:0] ADDR_WAIT_ENABLE  = 16'hff00;
   localparam logic [15:0] ADDR_WAIT_CONTROL = 16'hff01;

   // ****************************************************************
   // Reset values and field layout
   // ****************************************************************
   localparam logic [7:0] P6_DIR_RESET       = 8'h80;
   localparam logic [7:0] P6_DIR_RESET_EXP   = 8'hf8;
   localparam logic [7:0] P6_DATA_RESET      = 8'h80;
   localparam logic [7:0] P5_PULLUP_RESET    = 8'hf0;
   localparam logic [7:0] P5_DIR_RESET_13    = 8'hff;
   localparam logic [7:0] P5_DIR_RESET_57    = 8'hf0;
   localparam logic [7:0] WAIT_ENABLE_RESET  = 8'hff;
   localparam logic [7:0] WAIT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] READ_ONES          = 8'hff;
   localparam logic [7:0] P6_PIN_MASK        = 8'h39;
   localparam logic [7:0] P6_STORE_MASK      = 8'h46;
   localparam logic [7:0] P6_FIXED_ONE       = 8'h80;
   localparam logic [7:0] P5_PIN_MASK        = 8'h0f;
   localparam int         WAIT_MODE_HI_BIT   = 3;
   localparam int         P6_WR_BIT          = 5;
   localparam int         P6_RD_BIT          = 4;
   localparam int         P6_AS_BIT          = 3;
   localparam int         P6_WAIT_BIT        = 0;

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   localparam logic [2:0] MODE_1 = 3'h1;
   localparam logic [2:0] MODE_3 = 3'h3;
   localparam logic [2:0] MODE_5 = 3'h5;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_7 = 3'h7;

   typedef enum logic [2:0] {
      BUS_IDLE  = 3'b001,
      BUS_WAIT  = 3'b010,
      BUS_REPLY = 3'b100
   } bus_state_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [15:0] address;
      logic [7:0]  writedata;
   } bus_req_t;

   typedef struct packed {
      logic write_strobe_n;
      logic read_strobe_n;
      logic address_strobe_n;
   } bus_ctrl_t;

endpackage

// ### pin_sync.sv
// Three-stage synchroniser with agreement filter for a group of pin inputs.
module pin_sync (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_level
);

   logic [7:0] s1_r;
   logic [7:0] s2_r;
   logic [7:0] s3_r;

   // The first stage feeds only the second; a change counts once the
   // second and third stages agree, which rejects a single odd sample.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_r <= 8'h00;
         s2_r <= 8'h00;
         s3_r <= 8'h00;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_level <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               pin_level[i] <= s2_r[i];
            end
         end
      end
   end

endmodule

// ### avalon_slave.sv
// Avalon-MM slave front end: one wait state, then a one-cycle reply.
module avalon_slave (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [15:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [7:0]           avs_writedata,
   output logic                      avs_waitrequest,
   output logic                      req_valid,
   output port6_pkg::bus_req_t       req
);

   port6_pkg::bus_state_t state_r;

   // Waitrequest is high by default; the request is handed on one cycle
   // after it appears and released to the master the cycle after that.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r         <= port6_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         req_valid       <= 1'b0;
         req             <= '0;
      end else begin
         req_valid <= 1'b0;
         case (state_r)
            port6_pkg::BUS_IDLE: begin
               avs_waitrequest <= 1'b1;
               if (avs_read || avs_write) begin
                  req.read      <= avs_read;
                  req.write     <= avs_write;
                  req.address   <= avs_address;
                  req.writedata <= avs_writedata;
                  req_valid     <= 1'b1;
                  state_r       <= port6_pkg::BUS_WAIT;
               end
            end
            port6_pkg::BUS_WAIT: begin
               avs_waitrequest <= 1'b0;
               state_r         <= port6_pkg::BUS_REPLY;
            end
            port6_pkg::BUS_REPLY: begin
               avs_waitrequest <= 1'b1;
               state_r         <= port6_pkg::BUS_IDLE;
            end
            default: begin
               avs_waitrequest <= 1'b1;
               state_r         <= port6_pkg::BUS_IDLE;
            end
         endcase
      end
   end

endmodule

// ### port6_io_chk.sv
// Concurrent checks on the ports of the port 6 block.
module port6_io_chk (
   input wire logic                 core_clk,
   input wire logic                 rst,
   input wire logic                 hw_standby,
   input wire logic                 sw_standby,
   input wire logic [2:0]           op_mode,
   input wire logic [15:0]          avs_address,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic [7:0]           avs_readdata,
   input wire logic                 avs_waitrequest,
   input wire port6_pkg::bus_ctrl_t bus_ctrl,
   input wire logic                 wait_n,
   input wire logic [7:0]           p6_pin_out,
   input wire logic [7:0]           p6_pin_oe,
   input wire logic [3:0]           p5_pullup_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************
   // Sequences
   // ********************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   logic exp_mode;
   assign exp_mode = (op_mode == port6_pkg::MODE_1) ||
                     (op_mode == port6_pkg::MODE_3) ||
                     (op_mode == port6_pkg::MODE_5);

   sequence s_read_at(logic [15:0] a);
      avs_read && avs_waitrequest && avs_address == a ##2 !avs_waitrequest;
   endsequence
   // Three quiet cycles let the registered pin stage settle after reset.
   sequence s_bus_run;
      (exp_mode && !hw_standby)[*3];
   endsequence
   sequence s_quiet_standby;
      sw_standby && !hw_standby && !avs_write && !exp_mode;
   endsequence

   // ********************************
   // Assertions
   // ********************************
   a_pullup_mode_off:
      assert property (!op_mode[2] |-> p5_pullup_on == 4'h0)
      else $error("pull-up on in a mode without pull-ups");
   a_hw_standby_off:
      assert property (hw_standby[*3] |-> p5_pullup_on == 4'h0
                       && p6_pin_oe == 8'h00)
      else $error("pull-up or pin drive left on in hardware standby");
   a_pullup_hold:
      assert property (s_quiet_standby |=> $stable(p5_pullup_on))
      else $error("pull-up changed in software standby");
   a_out_hold:
      assert property (s_quiet_standby |=> $stable(p6_pin_oe)
                       && $stable(p6_pin_out))
      else $error("pin output changed in software standby");
   a_dir_reads_ones:
      assert property (s_read_at(port6_pkg::ADDR_P6_DIRECTION)
                       |-> avs_readdata == port6_pkg::READ_ONES)
      else $error("direction read not all ones");
   a_data_top_bit:
      assert property (s_read_at(port6_pkg::ADDR_P6_DATA) |-> avs_readdata[7])
      else $error("data bit 7 read as 0");
   a_strobe_drive:
      assert property (s_bus_run |=> p6_pin_oe[5:3] == 3'h7
                       && p6_pin_out[5:3] == $past(bus_ctrl))
      else $error("bus strobes not on pins 5 to 3");
   a_reserved_no_drive:
      assert property (p6_pin_oe[7:6] == 2'h0 && p6_pin_oe[2:1] == 2'h0)
      else $error("reserved bit drives a pin");
   a_wait_gpio_mode:
      assert property (!exp_mode |-> wait_n)
      else $error("wait asserted in single chip mode");
endmodule

bind port6_io port6_io_chk i_chk (
   .core_clk(core_clk), .rst(rst), .hw_standby(hw_standby),
   .sw_standby(sw_standby), .op_mode(op_mode), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .bus_ctrl(bus_ctrl), .wait_n(wait_n), .p6_pin_out(p6_pin_out),
   .p6_pin_oe(p6_pin_oe), .p5_pullup_on(p5_pullup_on)
);

// ### board_model.sv
// Board side of port 6: external drivers and undriven pins.
module board_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] p6_pin_out,
   input  wire logic [7:0] p6_pin_oe,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] p6_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Port 6 has no pull-ups, so a pin nobody drives toggles every cycle.
   logic [7:0] float_r = 8'h55;
   always_ff @(posedge core_clk) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         p6_pin_in[i] = p6_pin_oe[i] ? p6_pin_out[i]
                      : ext_en[i] ? ext_val[i] : float_r[i];
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the port 6 block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] dir, data, ext, pcr, p5dir, rd, oe;
      logic [3:0] pu;
   } row_t;
   logic                 core_clk      = 1'b0;
   logic                 rst           = 1'b1;
   logic                 hw_standby    = 1'b0;
   logic                 sw_standby    = 1'b0;
   logic [2:0]           op_mode       = port6_pkg::MODE_7;
   logic [15:0]          avs_address   = 16'h0000;
   logic                 avs_read      = 1'b0;
   logic                 avs_write     = 1'b0;
   logic [7:0]           avs_writedata = 8'h00;
   port6_pkg::bus_ctrl_t bus_ctrl      = 3'h7;
   logic [7:0]           ext_val       = 8'h00;
   logic [7:0]           avs_readdata, p6_pin_in, p6_pin_out, p6_pin_oe;
   logic                 avs_waitrequest, wait_n;
   logic [3:0]           p5_pullup_on;
   int                   n_errors      = 0;
   int                   compares      = 0;
   int                   cycles        = 0;
   row_t                 rows [5]      = '{
      '{8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h80, 8'h39, 4'hf},
      '{8'h00, 8'h7f, 8'h39, 8'hf5, 8'h00, 8'hff, 8'h00, 4'h5},
      '{8'h39, 8'h15, 8'h00, 8'hff, 8'h0c, 8'hd7, 8'h39, 4'h3},
      '{8'h46, 8'h66, 8'h28, 8'hf0, 8'h00, 8'hee, 8'h00, 4'h0},
      '{8'h21, 8'h01, 8'h18, 8'hfa, 8'h03, 8'hdf, 8'h21, 4'h8}};

   port6_io i_port6_io (
      .core_clk(core_clk), .rst(rst), .hw_standby(hw_standby),
      .sw_standby(sw_standby), .op_mode(op_mode),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_ctrl(bus_ctrl), .wait_n(wait_n), .p6_pin_in(p6_pin_in),
      .p6_pin_out(p6_pin_out), .p6_pin_oe(p6_pin_oe),
      .p5_pullup_on(p5_pullup_on));
   board_model i_board_model (
      .core_clk(core_clk), .p6_pin_out(p6_pin_out), .p6_pin_oe(p6_pin_oe),
      .ext_en(8'hff), .ext_val(ext_val), .p6_pin_in(p6_pin_in));

   // ********************************
   // Clock, timeout and tasks
   // ********************************
   always #12.5 core_clk = ~core_clk;

   task automatic report_and_stop;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      check(avs_readdata, exp);
      avs_read <= 1'b0;
   endtask

   // Mode is static, so every mode change goes through a full reset.
   task automatic do_reset(input logic [2:0] m);
      @(posedge core_clk);
      rst <= 1'b1;
      op_mode <= m;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // Covers the pin synchroniser latency plus the output register.
   task automatic settle;
      repeat (6) @(posedge core_clk);
   endtask

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      do_reset(port6_pkg::MODE_7);
      foreach (rows[i]) begin
         ext_val <= rows[i].ext;
         wr(port6_pkg::ADDR_P6_DIRECTION, rows[i].dir);
         wr(port6_pkg::ADDR_P6_DATA, rows[i].data);
         wr(port6_pkg::ADDR_P5_PULLUP, rows[i].pcr);
         wr(port6_pkg::ADDR_P5_DIRECTION, rows[i].p5dir);
         settle();
         rd_chk(port6_pkg::ADDR_P6_DATA, rows[i].rd);
         rd_chk(port6_pkg::ADDR_P5_PULLUP, rows[i].pcr);
         check(p6_pin_oe, rows[i].oe);
         check(p6_pin_out & rows[i].oe, rows[i].data & rows[i].oe);
         check({4'h0, p5_pullup_on}, {4'h0, rows[i].pu});
      end
      rd_chk(port6_pkg::ADDR_P6_DIRECTION, port6_pkg::READ_ONES);
      rd_chk(16'hffc0, 8'h00);
      sw_standby <= 1'b1;
      ext_val <= 8'hff;
      settle();
      check(p6_pin_oe, 8'h21);
      check(p6_pin_out & 8'h21, 8'h01);
      check({4'h0, p5_pullup_on}, 8'h08);
      sw_standby <= 1'b0;
      wr(port6_pkg::ADDR_P5_DIRECTION, 8'h00);
      wr(port6_pkg::ADDR_P5_PULLUP, 8'hff);
      wr(port6_pkg::ADDR_P6_DATA, 8'h46);
      hw_standby <= 1'b1;
      ext_val <= 8'h00;
      settle();
      check({4'h0, p5_pullup_on}, 8'h00);
      check(p6_pin_oe, 8'h00);
      hw_standby <= 1'b0;
      settle();
      check(p6_pin_oe, 8'h00);
      rd_chk(port6_pkg::ADDR_P6_DATA, 8'hc6);
      rd_chk(port6_pkg::ADDR_P5_PULLUP, port6_pkg::P5_PULLUP_RESET);
      wr(port6_pkg::ADDR_P6_DIRECTION, 8'h46);
      rd_chk(port6_pkg::ADDR_P6_DATA, 8'h80);
      do_reset(port6_pkg::MODE_5);
      bus_ctrl <= 3'h5;
      settle();
      rd_chk(port6_pkg::ADDR_P6_DATA, 8'h86);
      wr(port6_pkg::ADDR_P6_DIRECTION, 8'h01);
      wr(port6_pkg::ADDR_P6_DATA, 8'h01);
      wr(port6_pkg::ADDR_P5_PULLUP, 8'hff);
      wr(port6_pkg::ADDR_P5_DIRECTION, 8'h00);
      settle();
      check(p6_pin_oe, 8'h39);
      check(p6_pin_out & 8'h39, 8'h29);
      check({4'h0, p5_pullup_on}, 8'h0f);
      wr(port6_pkg::ADDR_P6_DIRECTION, 8'h00);
      wr(port6_pkg::ADDR_WAIT_CONTROL, 8'h08);
      settle();
      check({7'h0, wait_n}, 8'h00);
      check(p6_pin_oe, 8'h38);
      ext_val <= 8'h01;
      settle();
      check({7'h0, wait_n}, 8'h01);
      do_reset(port6_pkg::MODE_1);
      wr(port6_pkg::ADDR_P5_PULLUP, 8'hff);
      wr(port6_pkg::ADDR_P5_DIRECTION, 8'h00);
      settle();
      check({4'h0, p5_pullup_on}, 8'h00);
      rd_chk(port6_pkg::ADDR_P6_DATA, 8'h87);
      report_and_stop();
   end
endmodule
